// *** design/mic_pkg.sv ***
// constants shared by the interrupt controller files
package mic_pkg;
  // number of maskable sources
  localparam int NumSrc = 15;
  localparam logic [3:0] SrcW = 4'hF;
  // source indices in request vector
  localparam int SrcExt0 = 0;
  localparam int SrcExt1 = 1;
  localparam int SrcExt2 = 2;
  localparam int SrcExt3 = 3;
  localparam int SrcRx = 4;
  localparam int SrcTx = 5;
  localparam int SrcTmrA = 6;
  localparam int SrcTmrB = 7;
  localparam int SrcTmrC = 8;
  localparam int SrcTmrD = 9;
  localparam int SrcInterval = 10;
  localparam int SrcWatchdog = 11;
  localparam int SrcWatch = 12;
  localparam int SrcSpare0 = 13;
  localparam int SrcSpare1 = 14;
  // vector addresses
  localparam logic [15:0] VecReset = 16'hFFFE;
  localparam logic [15:0] VecExt0 = 16'hFFFA;
  localparam logic [15:0] VecExt1 = 16'hFFF8;
  localparam logic [15:0] VecExt2 = 16'hFFF6;
  localparam logic [15:0] VecExt3 = 16'hFFF4;
  localparam logic [15:0] VecSerial = 16'hFFF2;
  localparam logic [15:0] VecTmrA = 16'hFFEE;
  localparam logic [15:0] VecTmrB = 16'hFFEC;
  localparam logic [15:0] VecTmrC = 16'hFFEA;
  localparam logic [15:0] VecTmrD = 16'hFFE8;
  localparam logic [15:0] VecInterval = 16'hFFE2;
  localparam logic [15:0] VecWatch = 16'hFFE0;
  // break shares the table call 0 vector
  localparam logic [15:0] VecBreak = 16'hFFDE;
  // status word bits
  localparam int PswMasterBit = 2;
  localparam int PswBreakBit = 4;
  // register indices on the plain port
  localparam logic [3:0] RegEnHigh = 4'h0;
  localparam logic [3:0] RegEnMid = 4'h1;
  localparam logic [3:0] RegEnLow = 4'h2;
  localparam logic [3:0] RegReqHigh = 4'h3;
  localparam logic [3:0] RegReqMid = 4'h4;
  localparam logic [3:0] RegReqLow = 4'h5;
  localparam logic [3:0] RegAccHigh = 4'h6;
  localparam logic [3:0] RegAccLow = 4'h7;
  localparam logic [3:0] RegEdgeSel = 4'h8;
  localparam logic [3:0] RegPsw = 4'h9;
  localparam logic [7:0] PswReset = 8'h00;
  // acceptance takes eight oscillator periods
  localparam int AcceptPeriods = 8;
  localparam logic [3:0] AcceptLast = 4'(AcceptPeriods - 1);
  // edge select codes
  localparam logic [1:0] EdgeFall = 2'h1;
  localparam logic [1:0] EdgeRise = 2'h2;
  localparam logic [1:0] EdgeBoth = 2'h3;
  // sequencer states
  typedef enum logic [2:0] {
    MIC_IDLE = 3'b000,
    MIC_PUSH_PCH = 3'b001,
    MIC_PUSH_PCL = 3'b010,
    MIC_PUSH_PSW = 3'b011,
    MIC_FETCH = 3'b100,
    MIC_POP_PSW = 3'b101,
    MIC_POP_PCL = 3'b110,
    MIC_POP_PCH = 3'b111
  } mic_state_e;
endpackage

// *** design/mic_edge_detect.sv ***
// edge detector for one external interrupt input
`timescale 1ns/1ps
`default_nettype none
module mic_edge_detect (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin and selection
  input wire logic pinIn,
  input wire logic [1:0] edgeSel,
  // one cycle event
  output logic edgeHit
);
  import mic_pkg::*;
  logic prev_ff;
  logic nxt_prev;
  // previous pin level
  always_comb
  begin
    nxt_prev = pinIn;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prev_ff <= 1'b1;
    else
      prev_ff <= nxt_prev;
  end
  // falling, rising or both per selection
  always_comb
  begin
    edgeHit = 1'b0;
    if ((edgeSel == EdgeFall || edgeSel == EdgeBoth) && prev_ff && !pinIn)
      edgeHit = 1'b1;
    if ((edgeSel == EdgeRise || edgeSel == EdgeBoth) && !prev_ff && pinIn)
      edgeHit = 1'b1;
  end
endmodule
`default_nettype wire

// *** design/mic_priority.sv ***
// fixed priority pick and vector lookup
`timescale 1ns/1ps
`default_nettype none
module mic_priority (
  // qualified requests
  input wire logic [14:0] pending,
  // chosen source
  output logic found,
  output logic [3:0] srcIdx,
  output logic [15:0] vector
);
  import mic_pkg::*;
  // lowest index has highest priority
  always_comb
  begin
    found = 1'b0;
    srcIdx = SrcW;
    for (int i = NumSrc - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        found = 1'b1;
        srcIdx = 4'(i);
      end
    end
  end
  // vector table
  always_comb
  begin
    case (srcIdx)
      4'(SrcExt0): vector = VecExt0;
      4'(SrcExt1): vector = VecExt1;
      4'(SrcExt2): vector = VecExt2;
      4'(SrcExt3): vector = VecExt3;
      4'(SrcRx): vector = VecSerial;
      4'(SrcTx): vector = VecSerial;
      4'(SrcTmrA): vector = VecTmrA;
      4'(SrcTmrB): vector = VecTmrB;
      4'(SrcTmrC): vector = VecTmrC;
      4'(SrcTmrD): vector = VecTmrD;
      4'(SrcInterval): vector = VecInterval;
      4'(SrcWatchdog): vector = VecWatch;
      4'(SrcWatch): vector = VecWatch;
      default: vector = VecReset;
    endcase
  end
endmodule
`default_nettype wire

// *** design/mic_interrupt_controller.sv ***
// interrupt controller top: flags, enables, acceptance sequencer
`timescale 1ns/1ps
`default_nettype none
module mic_interrupt_controller (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // source events
  input wire logic [3:0] extPin,
  input wire logic serialRxDone,
  input wire logic serialTxDone,
  input wire logic [3:0] timerMatch,
  input wire logic intervalOverflow,
  input wire logic watchdogMatch,
  input wire logic watchdogResetSelect,
  input wire logic watchTick,
  // cpu core side
  input wire logic instrDone,
  input wire logic softwareBreak,
  input wire logic returnFromInterrupt,
  input wire logic setMasterEnable,
  input wire logic [15:0] cpuPc,
  input wire logic [7:0] stackRdData,
  output logic cpuHold,
  output logic [7:0] stackPtr,
  output logic stackWr,
  output logic [7:0] stackWrData,
  output logic pcLoad,
  output logic [15:0] pcLoadValue,
  output logic [7:0] psw,
  output logic [3:0] acceptedSrc
);
  import mic_pkg::*;

  logic [14:0] reqFlags_ff, nxt_reqFlags;
  logic [14:0] enable_ff, nxt_enable;
  logic [14:0] accFlags_ff, nxt_accFlags;
  logic [7:0] edgeSel_ff, nxt_edgeSel;
  logic [7:0] psw_ff, nxt_psw;
  logic [7:0] rdData_ff, nxt_rdData;
  mic_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sp_ff, nxt_sp;
  logic [15:0] retPc_ff, nxt_retPc;
  logic [15:0] vec_ff, nxt_vec;
  logic [3:0] src_ff, nxt_src;
  logic isBreak_ff, nxt_isBreak;
  logic [7:0] popPsw_ff, nxt_popPsw;
  logic [7:0] popPcl_ff, nxt_popPcl;
  // status word as it stood before acceptance, so a return restores it
  logic [7:0] savedPsw_ff, nxt_savedPsw;
  logic [3:0] extHit;
  logic [14:0] events;
  logic [14:0] pending;
  logic found;
  logic [3:0] pickIdx;
  logic [15:0] pickVec;
  logic stepDone;

  // one edge detector per external input
  for (genvar g = 0; g < 4; g++)
  begin : gEdge
    mic_edge_detect uEdge (
      .sys_clk(sys_clk),
      .rst(rst),
      .pinIn(extPin[g]),
      .edgeSel(edgeSel_ff[2*g+1:2*g]),
      .edgeHit(extHit[g])
    );
  end

  // hardware event vector
  always_comb
  begin
    events = '0;
    events[SrcExt3:SrcExt0] = extHit;
    events[SrcRx] = serialRxDone;
    events[SrcTx] = serialTxDone;
    events[SrcTmrD:SrcTmrA] = timerMatch;
    events[SrcInterval] = intervalOverflow;
    events[SrcWatchdog] = watchdogMatch && !watchdogResetSelect;
    events[SrcWatch] = watchTick;
  end

  // gating by master enable and per-source enable; break bypasses this
  assign pending = (psw_ff[PswMasterBit]) ?
    (reqFlags_ff & enable_ff) : '0;

  mic_priority uPrio (
    .pending(pending),
    .found(found),
    .srcIdx(pickIdx),
    .vector(pickVec)
  );

  // last period of a sequence: the counter load happens here
  assign stepDone = (cnt_ff == AcceptLast);

  // sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sp = sp_ff;
    nxt_retPc = retPc_ff;
    nxt_vec = vec_ff;
    nxt_src = src_ff;
    nxt_isBreak = isBreak_ff;
    nxt_popPsw = popPsw_ff;
    nxt_popPcl = popPcl_ff;
    nxt_psw = psw_ff;
    nxt_savedPsw = savedPsw_ff;
    stackWr = 1'b0;
    stackWrData = '0;
    pcLoad = 1'b0;
    pcLoadValue = vec_ff;
    if (setMasterEnable && state_ff == MIC_IDLE)
      nxt_psw[PswMasterBit] = 1'b1;
    case (state_ff)
      MIC_IDLE:
      begin
        nxt_cnt = '0;
        if (instrDone && found)
        begin
          nxt_state = MIC_PUSH_PCH;
          nxt_src = pickIdx;
          nxt_vec = pickVec;
          nxt_retPc = cpuPc;
          nxt_savedPsw = psw_ff;
          nxt_isBreak = 1'b0;
          nxt_psw[PswMasterBit] = 1'b0;
        end
        else if (instrDone && softwareBreak)
        begin
          nxt_state = MIC_PUSH_PCH;
          nxt_src = SrcW;
          nxt_vec = VecBreak;
          nxt_retPc = cpuPc;
          nxt_savedPsw = psw_ff;
          nxt_isBreak = 1'b1;
          nxt_psw[PswBreakBit] = 1'b1;
          nxt_psw[PswMasterBit] = 1'b0;
        end
        else if (instrDone && returnFromInterrupt)
        begin
          // a return frame is marked by the spare source code
          nxt_state = MIC_POP_PSW;
          nxt_src = SrcW - 4'h1;
          nxt_isBreak = 1'b0;
        end
      end
      // push high, low, status word; stack down each time
      MIC_PUSH_PCH:
      begin
        stackWr = 1'b1;
        stackWrData = retPc_ff[15:8];
        nxt_sp = sp_ff - 8'h01;
        nxt_state = MIC_PUSH_PCL;
      end
      MIC_PUSH_PCL:
      begin
        stackWr = 1'b1;
        stackWrData = retPc_ff[7:0];
        nxt_sp = sp_ff - 8'h01;
        nxt_state = MIC_PUSH_PSW;
      end
      MIC_PUSH_PSW:
      begin
        stackWr = 1'b1;
        stackWrData = savedPsw_ff;
        nxt_sp = sp_ff - 8'h01;
        nxt_state = MIC_FETCH;
      end
      // wait out the eight periods, then jump
      MIC_FETCH:
      begin
        if (stepDone)
        begin
          pcLoad = 1'b1;
          pcLoadValue = vec_ff;
          nxt_state = MIC_IDLE;
        end
      end
      // pop status word, then return address
      MIC_POP_PSW:
      begin
        nxt_sp = sp_ff + 8'h01;
        nxt_state = MIC_POP_PCL;
      end
      MIC_POP_PCL:
      begin
        nxt_popPsw = stackRdData;
        nxt_sp = sp_ff + 8'h01;
        nxt_state = MIC_POP_PCH;
      end
      MIC_POP_PCH:
      begin
        nxt_popPcl = stackRdData;
        nxt_sp = sp_ff + 8'h01;
        nxt_state = MIC_FETCH;
      end
      default:
        nxt_state = MIC_IDLE;
    endcase
    // one count per period of a sequence
    if (state_ff != MIC_IDLE && !stepDone)
      nxt_cnt = cnt_ff + 4'h1;
    // high byte sits at the restored pointer while the periods run out;
    // the pointer no longer moves, so the pair is stable until the load
    if (state_ff == MIC_FETCH && returnMode(src_ff, isBreak_ff))
      nxt_vec = {stackRdData, popPcl_ff};
    if (state_ff == MIC_FETCH && stepDone && returnMode(src_ff, isBreak_ff))
      nxt_psw = popPsw_ff;
  end

  // return frames are marked by the spare source code SrcSpare1 (14)
  function automatic logic returnMode(input logic [3:0] s, input logic b);
    returnMode = 1'b0;
    if (s == SrcW - 4'h1 && !b)
      returnMode = 1'b1;
  endfunction

  // flags, enables and software register writes
  always_comb
  begin
    nxt_reqFlags = reqFlags_ff;
    nxt_enable = enable_ff;
    nxt_accFlags = accFlags_ff;
    nxt_edgeSel = edgeSel_ff;
    nxt_rdData = '0;
    if (regWrEn)
    begin
      case (regAddr)
        RegEnHigh: nxt_enable[7:0] = regWrData;
        RegEnMid: nxt_enable[14:8] = regWrData[6:0];
        RegReqHigh: nxt_reqFlags[7:0] = regWrData;
        RegReqMid: nxt_reqFlags[14:8] = regWrData[6:0];
        RegAccHigh: nxt_accFlags[7:0] = regWrData;
        RegAccLow: nxt_accFlags[14:8] = regWrData[6:0];
        RegEdgeSel: nxt_edgeSel = regWrData;
        default: nxt_rdData = '0;
      endcase
    end
    // accepted source flag cleared after master enable drops
    if (state_ff == MIC_PUSH_PCH && !isBreak_ff && src_ff < SrcW)
      nxt_reqFlags[src_ff] = 1'b0;
    // events win over any clear in the same cycle
    nxt_reqFlags = nxt_reqFlags | events;
    nxt_accFlags = nxt_accFlags | (nxt_reqFlags & enable_ff);
    if (regRdEn)
    begin
      case (regAddr)
        RegEnHigh: nxt_rdData = enable_ff[7:0];
        RegEnMid: nxt_rdData = {1'b0, enable_ff[14:8]};
        RegReqHigh: nxt_rdData = reqFlags_ff[7:0];
        RegReqMid: nxt_rdData = {1'b0, reqFlags_ff[14:8]};
        RegAccHigh: nxt_rdData = accFlags_ff[7:0];
        RegAccLow: nxt_rdData = {1'b0, accFlags_ff[14:8]};
        RegEdgeSel: nxt_rdData = edgeSel_ff;
        RegPsw: nxt_rdData = psw_ff;
        default: nxt_rdData = '0;
      endcase
    end
  end

  // register all state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reqFlags_ff <= '0;
      enable_ff <= '0;
      accFlags_ff <= '0;
      edgeSel_ff <= '0;
      psw_ff <= PswReset;
      rdData_ff <= '0;
      state_ff <= MIC_IDLE;
      cnt_ff <= '0;
      sp_ff <= '1;
      retPc_ff <= '0;
      vec_ff <= '0;
      src_ff <= SrcW;
      isBreak_ff <= 1'b0;
      popPsw_ff <= '0;
      popPcl_ff <= '0;
      savedPsw_ff <= PswReset;
    end
    else
    begin
      reqFlags_ff <= nxt_reqFlags;
      enable_ff <= nxt_enable;
      accFlags_ff <= nxt_accFlags;
      edgeSel_ff <= nxt_edgeSel;
      psw_ff <= nxt_psw;
      rdData_ff <= nxt_rdData;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sp_ff <= nxt_sp;
      retPc_ff <= nxt_retPc;
      vec_ff <= nxt_vec;
      src_ff <= nxt_src;
      isBreak_ff <= nxt_isBreak;
      popPsw_ff <= nxt_popPsw;
      popPcl_ff <= nxt_popPcl;
      savedPsw_ff <= nxt_savedPsw;
    end
  end

  // outputs
  assign regRdData = rdData_ff;
  assign cpuHold = (state_ff != MIC_IDLE);
  assign stackPtr = sp_ff;
  assign psw = psw_ff;
  assign acceptedSrc = src_ff;
endmodule
`default_nettype wire

// *** tb/mic_assertions.sv ***
// port checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // cpu core side
  input wire logic instrDone,
  input wire logic softwareBreak,
  input wire logic returnFromInterrupt,
  input wire logic setMasterEnable,
  input wire logic [15:0] cpuPc,
  input wire logic cpuHold,
  input wire logic [7:0] stackPtr,
  input wire logic stackWr,
  input wire logic [7:0] stackWrData,
  input wire logic pcLoad,
  input wire logic [7:0] psw
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // with the master flag off only break and return may start a sequence
  masked_idle_a: assert property (instrDone && !cpuHold && !psw[2] &&
    !softwareBreak && !returnFromInterrupt && !setMasterEnable |=> !cpuHold)
    else $error("sequence started while masked");
  // master flag is already off in the first sequence cycle
  master_clear_a: assert property ($rose(cpuHold) &&
    !$past(returnFromInterrupt) && !$past(softwareBreak) |-> !psw[2])
    else $error("master flag still set in acceptance");
  // three pushes, four waits, then the vector load: eight periods
  push_walk_a: assert property ($rose(cpuHold) &&
    !$past(returnFromInterrupt) |-> stackWr[*3] ##1 (!stackWr)[*4] ##1 pcLoad)
    else $error("acceptance walk out of step");
  // each push moves the pointer down by one
  sp_step_a: assert property (stackWr |=>
    stackPtr == $past(stackPtr) - 8'h01)
    else $error("stack pointer step wrong");
  // return address goes out high byte first
  push_order_a: assert property ($rose(cpuHold) &&
    !$past(returnFromInterrupt) |-> stackWrData == 8'($past(cpuPc) >> 8)
    ##1 stackWrData == 8'($past(cpuPc, 2)))
    else $error("pushed return address wrong");
  // a return ends in a program counter load
  ret_load_a: assert property (instrDone && returnFromInterrupt &&
    !cpuHold |-> ##[1:12] pcLoad)
    else $error("return never reloaded the counter");
  // the load pulse is a single cycle
  load_once_a: assert property (pcLoad |=> !pcLoad)
    else $error("load pulse too long");
  // no stack traffic outside a sequence
  idle_quiet_a: assert property (!cpuHold |-> !stackWr)
    else $error("stack write while idle");
  // read data is zero unless a read was strobed
  read_idle_a: assert property (!$past(regRdEn) |->
    regRdData == 8'h00)
    else $error("read data outside read slot");
endmodule
bind mic_interrupt_controller mic_checker mic_checker_inst (.sys_clk,
  .rst, .regRdEn, .regRdData, .instrDone, .softwareBreak,
  .returnFromInterrupt, .setMasterEnable, .cpuPc, .cpuHold, .stackPtr,
  .stackWr, .stackWrData, .pcLoad, .psw);
`default_nettype wire

// *** tb/mic_cpu_model.sv ***
// behavioural cpu core facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_cpu_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bench commands
  input wire logic slow,
  input wire logic breakReq,
  input wire logic retReq,
  input wire logic enableReq,
  // controller side
  input wire logic cpuHold,
  input wire logic [7:0] stackPtr,
  input wire logic stackWr,
  input wire logic [7:0] stackWrData,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue,
  output logic instrDone,
  output logic softwareBreak,
  output logic returnFromInterrupt,
  output logic setMasterEnable,
  output logic [15:0] cpuPc,
  output logic [7:0] stackRdData
);
  logic [7:0] stackMem [256];
  logic [1:0] phase_ff;
  // instructions retire every cycle, or every fourth when slow
  assign instrDone = !rst && !cpuHold && !pcLoad &&
    (!slow || phase_ff == 2'h0);
  assign softwareBreak = breakReq && instrDone;
  assign returnFromInterrupt = retReq && instrDone;
  assign setMasterEnable = enableReq && !cpuHold;
  assign stackRdData = stackMem[stackPtr];
  // counter follows loads and retired instructions; stack memory
  always_ff @(posedge sys_clk)
  begin
    phase_ff <= rst ? 2'h0 : phase_ff + 2'h1;
    if (rst) cpuPc <= 16'h1000;
    else if (pcLoad) cpuPc <= pcLoadValue;
    else if (instrDone) cpuPc <= cpuPc + 16'h0001;
    if (stackWr) stackMem[stackPtr] <= stackWrData;
  end
endmodule
`default_nettype wire

// *** tb/mic_interrupt_controller_test.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_interrupt_controller_test;
  import mic_pkg::*;
  logic sys_clk, rst, regWrEn, regRdEn, wdSel, slow;
  logic breakReq, retReq, enableReq;
  logic instrDone, softwareBreak, returnFromInterrupt, setMasterEnable;
  logic cpuHold, stackWr, pcLoad;
  logic [3:0] regAddr, extPin, acceptedSrc;
  logic [7:0] regWrData, regRdData, stackRdData, stackPtr, stackWrData, psw;
  logic [7:0] a8, b8;
  logic [8:0] ev;
  logic [15:0] cpuPc, pcLoadValue, savedPc;
  int nErrors, checks, seed, k, s, off;
  mic_interrupt_controller mic_interrupt_controller_inst (.sys_clk, .rst,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .extPin,
    .serialRxDone(ev[0]), .serialTxDone(ev[1]), .timerMatch(ev[5:2]),
    .intervalOverflow(ev[6]), .watchdogMatch(ev[7]),
    .watchdogResetSelect(wdSel), .watchTick(ev[8]), .instrDone,
    .softwareBreak, .returnFromInterrupt, .setMasterEnable, .cpuPc,
    .stackRdData, .cpuHold, .stackPtr, .stackWr, .stackWrData, .pcLoad,
    .pcLoadValue, .psw, .acceptedSrc);
  mic_cpu_model mic_cpu_model_inst (.sys_clk, .rst, .slow, .breakReq, .retReq,
    .enableReq, .cpuHold, .stackPtr, .stackWr, .stackWrData, .pcLoad,
    .pcLoadValue, .instrDone, .softwareBreak, .returnFromInterrupt,
    .setMasterEnable, .cpuPc, .stackRdData);
  // clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // expected vector of each source
  function automatic logic [15:0] vecOf(input int i);
    case (i)
      0: return VecExt0;
      1: return VecExt1;
      2: return VecExt2;
      3: return VecExt3;
      4, 5: return VecSerial;
      6: return VecTmrA;
      7: return VecTmrB;
      8: return VecTmrC;
      9: return VecTmrD;
      10: return VecInterval;
      default: return VecWatch;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("counts: %0d checks, %0d mismatches", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask
  // wait for the load pulse, noting the counter before the hold
  task automatic serve(output logic [15:0] pc);
    int i;
    // the acceptance may come at the very next edge
    #1;
    if (!cpuHold) pc = cpuPc;
    for (i = 0; i < 60; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (pcLoad) break;
      if (cpuHold) {breakReq, retReq} <= 2'b00;
      else pc = cpuPc;
    end
    check(pcLoad, 1'b1);
  endtask
  task automatic ret(input logic m);
    logic [15:0] t;
    retReq <= 1'b1;
    serve(t);
    check(pcLoadValue, savedPc);
    // the restored status word lands with the load edge
    @(posedge sys_clk);
    #1 check(psw[2], m);
  endtask
  // raise one source's event; pins use fall, rise, both, fall
  task automatic trip(input int i);
    logic [1:0] m;
    m = 2'(i % 3 + 1);
    if (i < 4)
    begin
      wr(RegEdgeSel, 8'h00);
      extPin[i] <= (m == EdgeFall);
      wr(RegEdgeSel, {4{m}});
      @(posedge sys_clk);
      extPin[i] <= (m != EdgeFall);
    end
    else
    begin
      @(posedge sys_clk);
      ev[i-4] <= 1'b1;
      @(posedge sys_clk);
      ev <= '0;
    end
  endtask
  task automatic quiet;
    repeat (12)
    begin
      @(posedge sys_clk);
      #1 check(cpuHold, 1'b0);
    end
  endtask
  // hang guard: a generous multiple of the expected run length
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    seed = 10;
    {rst, regWrEn, regRdEn, wdSel, slow, breakReq, retReq, enableReq} = 8'h80;
    {regAddr, regWrData, extPin, ev} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (k = 0; k < 16; k++)
    begin
      rd(4'(k), a8);
      check(a8, 8'h00);
    end
    $display("reset values test done");
    wr(RegEnHigh, 8'hFF);
    wr(RegEnMid, 8'hFF);
    wr(RegEnLow, 8'hFF);
    trip(6);
    quiet;
    wr(RegReqHigh, 8'h00);
    wr(RegReqMid, 8'h00);
    wr(RegReqLow, 8'h00);
    trip(7);
    enableReq <= 1'b1;
    @(posedge sys_clk);
    enableReq <= 1'b0;
    serve(savedPc);
    check(pcLoadValue, VecTmrB);
    ret(1'b1);
    $display("masking test done");
    off = ($random(seed) & 15) % 13;
    for (k = 0; k < 13; k++)
    begin
      s = (k * 5 + off) % 13;
      slow <= 1'($random(seed));
      repeat ($random(seed) & 7) @(posedge sys_clk);
      if (s == 11)
      begin
        wdSel <= 1'b1;
        trip(11);
        quiet;
        wdSel <= 1'b0;
      end
      trip(s);
      serve(savedPc);
      check(pcLoadValue, vecOf(s));
      check(acceptedSrc, 16'(s));
      check(psw[2], 1'b0);
      ret(1'b1);
    end
    $display("source sweep test done");
    rd(RegAccHigh, a8);
    rd(RegAccLow, b8);
    check((a8 | b8) != 8'h00, 1'b1);
    wr(RegAccHigh, 8'h00);
    wr(RegAccLow, 8'h00);
    rd(RegAccLow, b8);
    check(b8, 8'h00);
    @(posedge sys_clk);
    ev <= 9'h005;
    @(posedge sys_clk);
    ev <= '0;
    serve(savedPc);
    check(pcLoadValue, VecSerial);
    ret(1'b1);
    serve(savedPc);
    check(pcLoadValue, VecTmrA);
    ret(1'b1);
    $display("priority test done");
    rd(RegPsw, a8);
    check(a8[PswMasterBit], 1'b1);
    breakReq <= 1'b1;
    serve(savedPc);
    check(pcLoadValue, VecBreak);
    check(psw[4], 1'b1);
    check(acceptedSrc, 16'(SrcW));
    ret(1'b1);
    check(psw[PswBreakBit], 1'b0);
    $display("break test done");
    end_of_test;
  end
endmodule
`default_nettype wire
